// [hdl/subswap_consts.svh]
`ifndef SUBSWAP_CONSTS_SVH
`define SUBSWAP_CONSTS_SVH
// Opcode patterns, compared against the opcode after masking
`define OPC_LIT_SUB_MASK 16'hFF00
`define OPC_LIT_SUB 16'h0800
`define OPC_FILE_MASK 16'hFC00
`define OPC_REG_SUB 16'h5C00
`define OPC_REG_SUB_B 16'h5800
`define OPC_SWAP 16'h3800
`define OPC_TBL_MASK 16'hFFFC
`define OPC_TBL_RD 16'h0008
// Field positions
`define BIT_DEST 9
`define BIT_ACCESS 8
`define MODE_LSB 0
// Access bank split: addresses below this go to bank 0, others to bank 15
`define ACCESS_SPLIT 8'h80
`define ACCESS_HIGH_BANK 4'hF
// Reset values
`define RST_BYTE 8'h00
`define RST_PTR 21'h000000
`define RST_FLAGS 5'h00
`endif

// [hdl/subswap_pkg.sv]
package subswap_pkg;
    // Table pointer update modes
    typedef enum logic [1:0] {
        TBL_NONE,
        TBL_POST_INC,
        TBL_POST_DEC,
        TBL_PRE_INC
    } tbl_mode_type;
    // Status flags
    typedef struct packed {
        logic negative;
        logic overflow;
        logic zero;
        logic digit_carry;
        logic carry;
    } flags_type;
    // File register write request
    typedef struct packed {
        logic en;
        logic [11:0] addr;
        logic [7:0] data;
    } file_wr_type;
endpackage

// [hdl/subswap_exec.sv]
`timescale 1ns/100ps
`include "subswap_consts.svh"
// Summary of operation
// (RULE1) Immediate subtract computes literal minus accumulator into accumulator, all five flags.
// (RULE2) Register subtract computes file register minus accumulator, all five flags.
// (RULE3) Subtract with borrow also takes away the inverted carry flag.
// (RULE4) Destination bit zero sends the result to the accumulator, one to the file register.
// (RULE5) Access bit zero selects the access bank, one uses the bank selector.
// (RULE6) Nibble exchange swaps the halves of the register into the destination, flags untouched.
// (RULE7) Table read loads the program byte at the pointer into the latch, flags untouched.
// (RULE8) The two low opcode bits pick none, post-increment, post-decrement or pre-increment.
// (RULE9) The table pointer is 21 bits, a 2 Mbyte byte address.
// (RULE10) Pointer bit 0 picks low (0) or high (1) byte of a program word.
// (RULE11) Pre-increment bumps the pointer before the read.
// (RULE12) Post-increment and post-decrement read first, then change the pointer.
// (RULE13) Only those four pointer update modes exist.
// (RULE14) Carry is set when no borrow occurs and cleared on borrow.
// (RULE15) Zero flags an all-zero result, negative copies result bit 7.
module subswap_exec #(
    parameter int PTR_W = 21
) (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire logic i_exec,
    input wire logic [15:0] i_opcode,
    input wire logic [3:0] i_bank_selector,
    input wire logic [7:0] i_file_rd_data,
    input wire logic [7:0] i_prog_rd_data,
    input wire logic i_ptr_wr,
    input wire logic [20:0] i_ptr_wr_data,
    input wire logic i_acc_wr,
    input wire logic [7:0] i_acc_wr_data,
    output logic [11:0] o_file_rd_addr,
    output subswap_pkg::file_wr_type o_file_wr,
    output logic o_prog_rd,
    output logic [20:0] o_prog_addr,
    output logic [7:0] o_acc,
    output subswap_pkg::flags_type o_flags,
    output logic [20:0] o_prog_byte_pointer,
    output logic [7:0] o_prog_byte_latch,
    output logic o_busy
);
    // Pointer ports are fixed at 21 bits, so any other width is refused up front
    if (PTR_W != 21) begin : g_ptr_w_check
        $error("subswap_exec serves a 21 bit pointer only");
    end

    // Subtract a - b - borrow_in, giving result and flags
    function automatic subswap_pkg::flags_type sub_flags(input logic [7:0] a,
            input logic [7:0] b, input logic bin, output logic [7:0] res);
        logic [8:0] full;
        logic [4:0] low;
        subswap_pkg::flags_type f;
        full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
        res = full[7:0];
        f.carry = ~full[8]; // RULE14
        f.digit_carry = ~low[4];
        f.zero = (full[7:0] == 8'h00); // RULE15
        f.negative = full[7]; // RULE15
        f.overflow = (a[7] != b[7]) && (full[7] != a[7]);
        return f;
    endfunction

    // Opcode match under a mask, shared by all five decoders
    function automatic logic op_match(input logic [15:0] opc, input logic [15:0] mask,
            input logic [15:0] pattern);
        return (opc & mask) == pattern;
    endfunction

    // Instruction decode
    logic is_lit, is_sub, is_subb, is_swap, is_tbl;
    assign is_lit = i_exec && op_match(i_opcode, `OPC_LIT_SUB_MASK, `OPC_LIT_SUB);
    assign is_sub = i_exec && op_match(i_opcode, `OPC_FILE_MASK, `OPC_REG_SUB);
    assign is_subb = i_exec && op_match(i_opcode, `OPC_FILE_MASK, `OPC_REG_SUB_B);
    assign is_swap = i_exec && op_match(i_opcode, `OPC_FILE_MASK, `OPC_SWAP);
    assign is_tbl = i_exec && !o_busy
        && op_match(i_opcode, `OPC_TBL_MASK, `OPC_TBL_RD);

    subswap_pkg::tbl_mode_type mode;
    assign mode = subswap_pkg::tbl_mode_type'(i_opcode[`MODE_LSB +: 2]); // RULE8 RULE13

    // Address forming, file read is combinational from the partner
    logic [11:0] next_addr;
    always_comb begin
        if (i_opcode[`BIT_ACCESS]) begin
            next_addr = {i_bank_selector, i_opcode[7:0]}; // RULE5
        end else if (i_opcode[7:0] < `ACCESS_SPLIT) begin
            next_addr = {4'h0, i_opcode[7:0]}; // RULE5
        end else begin
            next_addr = {`ACCESS_HIGH_BANK, i_opcode[7:0]};
        end
    end
    // Read address registered: partner data valid the cycle after
    logic [11:0] rd_addr;
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            o_file_rd_addr <= 12'h000;
        end else begin
            o_file_rd_addr <= next_addr;
        end
    end
    assign rd_addr = o_file_rd_addr;

    // Arithmetic stage: op decoded in cycle 0, executed in cycle 1 with file data
    logic st_lit, st_sub, st_subb, st_swap, st_dest;
    logic [7:0] st_lit_val;
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            st_lit <= 1'b0;
            st_sub <= 1'b0;
            st_subb <= 1'b0;
            st_swap <= 1'b0;
            st_dest <= 1'b0;
            st_lit_val <= `RST_BYTE;
        end else begin
            st_lit <= is_lit;
            st_sub <= is_sub;
            st_subb <= is_subb;
            st_swap <= is_swap;
            st_dest <= i_opcode[`BIT_DEST];
            st_lit_val <= i_opcode[7:0];
        end
    end

    logic [7:0] res;
    subswap_pkg::flags_type nf;
    always_comb begin
        res = 8'h00;
        nf = o_flags;
        if (st_lit) begin
            nf = sub_flags(st_lit_val, o_acc, 1'b0, res); // RULE1
        end else if (st_sub) begin
            nf = sub_flags(i_file_rd_data, o_acc, 1'b0, res); // RULE2
        end else if (st_subb) begin
            nf = sub_flags(i_file_rd_data, o_acc, ~o_flags.carry, res); // RULE3
        end else if (st_swap) begin
            res = {i_file_rd_data[3:0], i_file_rd_data[7:4]}; // RULE6
        end
    end

    logic to_file;
    assign to_file = (st_sub || st_subb || st_swap) && st_dest;

    // Accumulator and flags
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            o_acc <= `RST_BYTE;
            o_flags <= `RST_FLAGS;
        end else begin
            if ((st_lit || st_sub || st_subb || st_swap) && !to_file) begin
                o_acc <= res; // RULE1 RULE4
            end else if (i_acc_wr) begin
                o_acc <= i_acc_wr_data;
            end
            if (st_lit || st_sub || st_subb) begin
                o_flags <= nf; // Swap leaves flags alone RULE6
            end
        end
    end

    // File write-back
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            o_file_wr <= '0;
        end else begin
            o_file_wr.en <= to_file; // RULE4
            o_file_wr.addr <= rd_addr;
            o_file_wr.data <= res;
        end
    end

    // Table read: cycle 0 issues address, cycle 1 latches byte
    logic tbl_pend;
    logic [20:0] next_ptr;
    always_comb begin
        case (mode)
            subswap_pkg::TBL_POST_INC: next_ptr = o_prog_byte_pointer + 21'h000001;
            subswap_pkg::TBL_POST_DEC: next_ptr = o_prog_byte_pointer - 21'h000001; // RULE12
            subswap_pkg::TBL_PRE_INC: next_ptr = o_prog_byte_pointer + 21'h000001; // RULE11
            default: next_ptr = o_prog_byte_pointer;
        endcase
    end
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            o_prog_byte_pointer <= `RST_PTR;
            o_prog_addr <= `RST_PTR;
            o_prog_rd <= 1'b0;
            tbl_pend <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_prog_rd <= is_tbl; // RULE7
            tbl_pend <= is_tbl;
            o_busy <= is_tbl;
            if (is_tbl) begin
                // Pre-increment reads the new address, others the old one
                o_prog_addr <= (mode == subswap_pkg::TBL_PRE_INC) ? next_ptr
                    : o_prog_byte_pointer; // RULE9 RULE10 RULE11 RULE12
                o_prog_byte_pointer <= next_ptr; // RULE13
            end else if (i_ptr_wr) begin
                o_prog_byte_pointer <= i_ptr_wr_data;
            end
        end
    end
    // Byte lane select is done by the partner from address bit 0
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            o_prog_byte_latch <= `RST_BYTE;
        end else if (tbl_pend) begin
            o_prog_byte_latch <= i_prog_rd_data; // RULE7
        end
    end

    AST_PREINC: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE11
        is_tbl && mode == subswap_pkg::TBL_PRE_INC |=> o_prog_addr == o_prog_byte_pointer)
        else $error("pre-increment address wrong");
    AST_POSTDEC: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE12
        is_tbl && mode == subswap_pkg::TBL_POST_DEC
        |=> o_prog_byte_pointer == o_prog_addr - 21'h000001)
        else $error("post-decrement pointer wrong");
    AST_NOCHG: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE8
        is_tbl && mode == subswap_pkg::TBL_NONE |=> $stable(o_prog_byte_pointer))
        else $error("pointer moved in no-change mode");
    AST_LATCH: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE7
        is_tbl |=> o_prog_rd ##1 o_prog_byte_latch == $past(i_prog_rd_data))
        else $error("latch not loaded");
    AST_SWAPFLAG: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE6
        st_swap |=> $stable(o_flags))
        else $error("swap altered flags");
    AST_DEST: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE4
        (is_sub || is_subb || is_swap) && i_opcode[`BIT_DEST] |=> ##1 o_file_wr.en)
        else $error("file write missing");
    AST_ZERO: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE15
        st_lit |=> o_flags.zero == (o_acc == 8'h00) && o_flags.negative == o_acc[7])
        else $error("zero or negative flag wrong");
    AST_CARRY: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE14
        st_lit |=> o_flags.carry == ($past(st_lit_val) >= $past(o_acc)))
        else $error("carry not inverted borrow");
    AST_BANK: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE5
        i_opcode[`BIT_ACCESS] |=> o_file_rd_addr[11:8] == $past(i_bank_selector))
        else $error("bank selector not used");

    // Literal result lands in the accumulator
    AST_LITACC: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE1
        st_lit |=> o_acc == $past(st_lit_val) - $past(o_acc))
        else $error("literal subtract result wrong");
    // Nibble borrow seen as inverted digit carry
    AST_LITDC: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE1
        st_lit |=> o_flags.digit_carry == ($past(st_lit_val[3:0]) >= $past(o_acc[3:0])))
        else $error("digit carry wrong");
    // Signed overflow: operand signs differ and result sign leaves the minuend's
    AST_LITOV: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE1
        st_lit |=> o_flags.overflow
        == ($past(st_lit_val[7]) != $past(o_acc[7]) && o_acc[7] != $past(st_lit_val[7])))
        else $error("overflow flag wrong");
    // Register subtract written back to the file
    AST_SUBFILE: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE2 RULE4
        st_sub && st_dest
        |=> o_file_wr.en && o_file_wr.data == $past(i_file_rd_data) - $past(o_acc))
        else $error("register subtract write-back wrong");
    // Register subtract kept in the accumulator, no file write
    AST_SUBACC: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE2 RULE4
        st_sub && !st_dest
        |=> !o_file_wr.en && o_acc == $past(i_file_rd_data) - $past(o_acc))
        else $error("register subtract accumulator wrong");
    // Borrow is the inverted carry flag as it stood before the subtract
    AST_SUBB: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE3
        st_subb && !st_dest
        |=> o_acc == $past(i_file_rd_data) - $past(o_acc) - {7'h00, !$past(o_flags.carry)})
        else $error("borrow subtract result wrong");
    // Carry on register subtract is the inverted borrow
    AST_SUBCARRY: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE14
        st_sub |=> o_flags.carry == ($past(i_file_rd_data) >= $past(o_acc)))
        else $error("register subtract carry wrong");
    // Zero and negative follow the stored result
    AST_SUBZERO: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE15
        (st_sub || st_subb) && !st_dest
        |=> o_flags.zero == (o_acc == 8'h00) && o_flags.negative == o_acc[7])
        else $error("register subtract zero or negative wrong");
    // Swap into the accumulator exchanges the halves
    AST_SWAPRES: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE6
        st_swap && !st_dest
        |=> o_acc == {$past(i_file_rd_data[3:0]), $past(i_file_rd_data[7:4])})
        else $error("swap result wrong");
    // Destination zero never touches the file
    AST_NODEST: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE4
        (is_sub || is_subb || is_swap) && !i_opcode[`BIT_DEST] |=> ##1 !o_file_wr.en)
        else $error("unexpected file write");
    // Access bank ignores the bank selector
    AST_ACCESS0: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE5
        i_exec && !i_opcode[`BIT_ACCESS] |=> o_file_rd_addr[11:8]
        == (($past(i_opcode[7:0]) < `ACCESS_SPLIT) ? 4'h0 : `ACCESS_HIGH_BANK))
        else $error("access bank wrong");
    // Offset within the bank comes from the opcode
    AST_OFFSET: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE5
        i_exec |=> o_file_rd_addr[7:0] == $past(i_opcode[7:0]))
        else $error("file offset wrong");
    // Post-increment reads the old byte, then moves on
    AST_POSTINC: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE12
        is_tbl && mode == subswap_pkg::TBL_POST_INC
        |=> o_prog_byte_pointer == o_prog_addr + 21'h000001)
        else $error("post-increment pointer wrong");
    // No-change mode reads at the pointer itself
    AST_NONEADDR: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE8
        is_tbl && mode == subswap_pkg::TBL_NONE |=> o_prog_addr == o_prog_byte_pointer)
        else $error("no-change read address wrong");
    // A table read issued while busy is dropped
    AST_BUSY: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE7
        o_busy |=> !o_prog_rd)
        else $error("table read accepted while busy");
    // Table read leaves the flags alone
    AST_TBLFLAG: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE7
        o_prog_rd |=> $stable(o_flags))
        else $error("table read altered flags");
    // Software load of the full pointer width
    AST_PTRLOAD: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST) // RULE9
        i_ptr_wr && !is_tbl |=> o_prog_byte_pointer == $past(i_ptr_wr_data))
        else $error("pointer load wrong");
endmodule

// [verification/mem_model.sv]
`timescale 1ns/100ps
// Program memory and file register array behind the datapath
module mem_model (
    input wire logic i_clk,
    input wire logic [11:0] i_file_rd_addr,
    input wire subswap_pkg::file_wr_type i_file_wr,
    input wire logic i_prog_rd,
    input wire logic [20:0] i_prog_addr,
    output logic [7:0] o_file_rd_data,
    output logic [7:0] o_prog_rd_data
);
    logic [7:0] file_mem [4096];
    logic [7:0] last_byte = 8'h00;
    logic [15:0] word;
    // File data follows the address at once; the datapath samples it next edge
    assign o_file_rd_data = file_mem[i_file_rd_addr];
    // Word content is a cheap hash of the word address
    assign word = {i_prog_addr[8:1] ^ i_prog_addr[20:13], i_prog_addr[8:1] + 8'h5A};
    // Bit 0 picks the byte; an idle bus shows the inverse, never a stale match
    assign o_prog_rd_data = !i_prog_rd ? ~last_byte
        : i_prog_addr[0] ? word[15:8] : word[7:0];
    // Write-back lands on the edge after the pulse shows
    always @(posedge i_clk) begin
        if (i_file_wr.en) begin
            file_mem[i_file_wr.addr] <= i_file_wr.data;
        end
        if (i_prog_rd) begin
            last_byte <= o_prog_rd_data;
        end
    end
endmodule

// [verification/tb.sv]
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic exec = 1'b0;
    logic [15:0] opcode = 16'h0000;
    logic [3:0] bank = 4'h0;
    logic ld = 1'b0;
    logic [20:0] ld_ptr = 21'h000000;
    logic [7:0] ld_acc = 8'h00;
    logic [7:0] file_rd_data, prog_rd_data, acc, latch;
    logic [11:0] file_rd_addr, addr;
    subswap_pkg::file_wr_type file_wr;
    subswap_pkg::flags_type flags;
    subswap_pkg::flags_type exp_flags = 5'h00;
    logic prog_rd, busy, d, ac;
    logic [20:0] prog_addr, ptr, p, ea, ep;
    logic [7:0] a, v, f;
    logic [3:0] bv;
    logic [1:0] mode;
    logic [15:0] op;
    logic [12:0] r;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int kind;

    subswap_exec dut_u (.I_SYS_CLK(clk), .I_SYS_RST(rst), .i_exec(exec), .i_opcode(opcode),
        .i_bank_selector(bank), .i_file_rd_data(file_rd_data), .i_prog_rd_data(prog_rd_data),
        .i_ptr_wr(ld), .i_ptr_wr_data(ld_ptr), .i_acc_wr(ld), .i_acc_wr_data(ld_acc),
        .o_file_rd_addr(file_rd_addr), .o_file_wr(file_wr), .o_prog_rd(prog_rd),
        .o_prog_addr(prog_addr), .o_acc(acc), .o_flags(flags), .o_prog_byte_pointer(ptr),
        .o_prog_byte_latch(latch), .o_busy(busy));
    mem_model mdl_u (.i_clk(clk), .i_file_rd_addr(file_rd_addr), .i_file_wr(file_wr),
        .i_prog_rd(prog_rd), .i_prog_addr(prog_addr), .o_file_rd_data(file_rd_data),
        .o_prog_rd_data(prog_rd_data));

    // Free-running 200 MHz clock
    always #2.5 clk = ~clk;

    // Flags and result of x - y - borrow: {n, ov, z, dc, c, result}
    function automatic logic [12:0] sub_ref(input logic [7:0] x, y, input logic bin);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, x} - {1'b0, y} - {8'h00, bin};
        h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, bin};
        return {s[7], (x[7] != y[7]) && (s[7] != x[7]), s[7:0] == 8'h00, ~h[4], ~s[8], s[7:0]};
    endfunction

    // Expected program byte, same hash the memory holds
    function automatic logic [7:0] prog_byte(input logic [20:0] ad);
        logic [15:0] w;
        w = {ad[8:1] ^ ad[20:13], ad[8:1] + 8'h5A};
        return ad[0] ? w[15:8] : w[7:0];
    endfunction

    task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flags(input subswap_pkg::flags_type exp, input subswap_pkg::flags_type got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch flags expected %b seen %b", exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            give_verdict();
        end
    end

    // Each pass: load acc and pointer, preload the file byte, issue one instruction
    initial begin
        void'($urandom(4));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 80; i++) begin
            kind = i % 5;
            a = (i < 15) ? 8'(i / 5 + 1) : 8'($urandom);
            v = (i < 15) ? 8'h02 : 8'($urandom);
            f = 8'($urandom);
            bv = 4'($urandom);
            {d, ac} = 2'($urandom);
            mode = 2'(i / 5);
            p = (i < 20) ? 21'h1FFFFF : (i < 40) ? 21'h000000 : 21'($urandom);
            addr = ac ? {bv, f} : {(f < 8'h80) ? 4'h0 : 4'hF, f};
            op = (kind == 0) ? {8'h08, v} : (kind == 1) ? {6'h17, d, ac, f} :
                (kind == 2) ? {6'h16, d, ac, f} : (kind == 3) ? {6'h0E, d, ac, f} :
                {14'h0002, mode};
            @(posedge clk);
            ld <= 1'b1;
            ld_acc <= a;
            ld_ptr <= p;
            bank <= bv;
            @(posedge clk);
            ld <= 1'b0;
            mdl_u.file_mem[addr] = v;
            @(posedge clk);
            exec <= 1'b1;
            opcode <= op;
            @(posedge clk);
            exec <= 1'b0;
            #1;
            if (kind == 4) begin
                ea = (mode == 2'h3) ? p + 21'h1 : p;
                ep = mode[0] ? p + 21'h1 : (mode == 2'h2) ? p - 21'h1 : p;
                chk("read strobe", 21'h1, prog_rd);
                chk("read address", ea, prog_addr);
                chk("pointer", ep, ptr);
                chk("busy", 21'h1, busy);
                @(posedge clk);
                #1;
                chk("latch", prog_byte(ea), latch);
            end else begin
                if (kind == 3) begin
                    r = {exp_flags, v[3:0], v[7:4]};
                end else begin
                    r = sub_ref(v, a, kind == 2 && !exp_flags.carry);
                end
                @(posedge clk);
                #1;
                exp_flags = r[12:8];
                if (kind != 0) begin
                    chk("file address", addr, file_rd_addr);
                end
                chk("write enable", kind != 0 && d, file_wr.en);
                if (kind != 0 && d) begin
                    chk("write address", addr, file_wr.addr);
                    chk("write back", r[7:0], file_wr.data);
                end else begin
                    chk("accumulator", r[7:0], acc);
                end
            end
            chk_flags(exp_flags, flags);
            $display("test %0d kind %0d done", i, kind);
        end
        // Corner: execute held two cycles, so the second table read meets busy
        @(posedge clk);
        ld <= 1'b1;
        ld_ptr <= 21'h00A356;
        @(posedge clk);
        ld <= 1'b0;
        exec <= 1'b1;
        opcode <= 16'h0009;
        @(posedge clk);
        @(posedge clk);
        exec <= 1'b0;
        #1;
        chk("busy pointer", 21'h00A357, ptr);
        chk("busy strobe", 21'h0, prog_rd);
        chk("busy latch", prog_byte(21'h00A356), latch);
        chk_flags(exp_flags, flags);
        $display("test busy refusal done");
        give_verdict();
    end
endmodule
